// ==== logic/mpss_device.sv ====
// Module end: power-on, emergency shutdown and sleep sequencing
//
// How it works
// - Host holds power request low 25 ms
// - I/O rail rises within 25 ms
// - Commands usable about 7 s after request
// - Clear-to-send falls when commands accepted
// - USB ready only after enumeration completes
// - Host pulses emergency reset low 20 ms
// - Valid emergency pulse shuts down, clears memory
// - Host uses emergency reset only when frozen
// - Power-off command switches module off orderly
// - Policy 0: sleep on DTR high, wake low
// - Policy 1: sleep when idle, wake 0x00
// - Policy 2: never sleep
// - Host picks policy 1 when USB used
`timescale 1ns/1ps
module mpss_device
  import mpss_pkg::*;
#(
  parameter logic [31:0] PWR_ON_CYC = PWR_ON_MIN_CYC,
  parameter logic [31:0] READY_CYC = CMD_READY_CYC,
  parameter logic [31:0] EMERG_CYC = EMERG_PULSE_CYC,
  parameter logic [31:0] SLEEP_CYC = SLEEP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic reset,
  mpss_link_if.dev link,
  input wire logic tasks_idle,
  output logic powered,
  output logic sleeping,
  output logic mem_clear,
  output logic [1:0] policy
);

  // All state of the module in one record
  typedef struct packed {
    mpss_dev_state_e state;
    logic [1:0] pwr_sync;
    logic [1:0] rst_sync;
    logic [31:0] tmr;
    logic [31:0] rst_cnt;
    logic [1:0] policy;
    logic rail;
    logic cts_n;
    logic mem_clear;
  } mpss_dev_s;

  mpss_dev_s state_ff;
  mpss_dev_s nxt_state;

  // Synchronised pin levels, taken from second stages only
  logic pwr_low;
  logic rst_low;
  logic emerg_hit;
  logic cmd_take;

  assign pwr_low = ~state_ff.pwr_sync[1];
  assign rst_low = ~state_ff.rst_sync[1];

  // Emergency fires once, on the last cycle of a full-length pulse
  assign emerg_hit = rst_low && !pwr_low && (state_ff.rst_cnt == EMERG_CYC - 32'h1);

  // Commands are taken only while awake and announced ready
  assign cmd_take = link.cmd_valid && link.cmd_ready;

  // Handshake outputs
  always_comb begin
    link.cmd_ready = (state_ff.state == DEV_READY) && !state_ff.cts_n;
    link.usb_ready = (state_ff.state == DEV_READY) && link.usb_enum_done;
  end

  // Pin and user outputs straight from flip-flops
  always_comb begin
    link.io_supply_indicator = state_ff.rail;
    link.host_uart_clear_to_send = state_ff.cts_n;
    powered = state_ff.rail;
    sleeping = (state_ff.state == DEV_SLEEP);
    mem_clear = state_ff.mem_clear;
    policy = state_ff.policy;
  end

  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_state.mem_clear = 1'b0;

    // Two-stage synchronisers on both control pins
    nxt_state.pwr_sync = {state_ff.pwr_sync[0], link.power_on_request_n};
    nxt_state.rst_sync = {state_ff.rst_sync[0], link.emerg_reset_n};

    // Emergency pulse width counter; it holds at the limit so a long pulse
    // cannot fire twice, and a power request during it voids the pulse
    if (rst_low && !pwr_low) begin
      if (state_ff.rst_cnt != EMERG_CYC) begin
        nxt_state.rst_cnt = state_ff.rst_cnt + 32'h1;
      end
    end else begin
      nxt_state.rst_cnt = CNT_RST;
    end

    case (state_ff.state)
      // Off: time the power request low level
      DEV_OFF: begin
        if (pwr_low) begin
          nxt_state.tmr = state_ff.tmr + 32'h1;
          if (state_ff.tmr == PWR_ON_CYC - 32'h1) begin
            // Rail comes up the moment the start is recognised
            nxt_state.state = DEV_BOOT;
            nxt_state.rail = 1'b1;
          end
        end else begin
          nxt_state.tmr = CNT_RST;
        end
      end
      // Boot: the request pin may be left open from here on
      DEV_BOOT: begin
        nxt_state.tmr = state_ff.tmr + 32'h1;
        if (state_ff.tmr == READY_CYC - 32'h1) begin
          // Timer started with the request, so this marks the full span
          nxt_state.state = DEV_READY;
          nxt_state.cts_n = 1'b0;
          nxt_state.tmr = CNT_RST;
        end
      end
      // Ready: commands and sleep entry
      DEV_READY: begin
        nxt_state.tmr = CNT_RST;
        if (cmd_take && link.cmd_op == CMD_POWER_OFF) begin
          // Orderly switch-off keeps the stored policy
          nxt_state.state = DEV_OFF;
          nxt_state.rail = 1'b0;
          nxt_state.cts_n = 1'b1;
        end else if (cmd_take && link.cmd_op == CMD_SLEEP_POLICY) begin
          // Unknown policy codes are ignored
          if (link.cmd_arg != 2'h3) begin
            nxt_state.policy = link.cmd_arg;
          end
        end else begin
          case (state_ff.policy)
            POLICY_DTR: begin
              if (link.dtr_n) begin
                nxt_state.tmr = state_ff.tmr + 32'h1;
                if (state_ff.tmr == SLEEP_CYC - 32'h1) begin
                  nxt_state.state = DEV_SLEEP;
                  nxt_state.cts_n = 1'b1;
                end
              end
            end
            POLICY_AUTO: begin
              // A pending command counts as a running task
              if (tasks_idle && !link.cmd_valid) begin
                nxt_state.state = DEV_SLEEP;
                nxt_state.cts_n = 1'b1;
              end
            end
            POLICY_NEVER: begin
              nxt_state.state = DEV_READY;
            end
            default: begin
              nxt_state.state = DEV_READY;
            end
          endcase
        end
      end
      // Sleep: commands refused until the policy's wake event
      DEV_SLEEP: begin
        case (state_ff.policy)
          POLICY_DTR: begin
            if (!link.dtr_n) begin
              nxt_state.state = DEV_READY;
              nxt_state.cts_n = 1'b0;
            end
          end
          POLICY_AUTO: begin
            if (link.ser_valid && link.ser_data == WAKE_CHAR) begin
              nxt_state.state = DEV_READY;
              nxt_state.cts_n = 1'b0;
            end
          end
          default: begin
            nxt_state.state = DEV_READY;
            nxt_state.cts_n = 1'b0;
          end
        endcase
      end
      default: begin
        nxt_state.state = DEV_OFF;
      end
    endcase

    // Emergency shutdown overrides everything and wipes held state
    if (emerg_hit && state_ff.state != DEV_OFF) begin
      nxt_state.state = DEV_OFF;
      nxt_state.rail = 1'b0;
      nxt_state.cts_n = 1'b1;
      nxt_state.tmr = CNT_RST;
      nxt_state.policy = POLICY_RST;
      nxt_state.mem_clear = 1'b1;
    end
  end

  // State register; synchronisers reset to the idle-high level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff.state <= DEV_OFF;
      state_ff.pwr_sync <= SYNC_RST;
      state_ff.rst_sync <= SYNC_RST;
      state_ff.tmr <= CNT_RST;
      state_ff.rst_cnt <= CNT_RST;
      state_ff.policy <= POLICY_RST;
      state_ff.rail <= 1'b0;
      state_ff.cts_n <= 1'b1;
      state_ff.mem_clear <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Note: a power request that ends early restarts the timing from zero,
  // trading a slower retry for immunity to glitches on the open-drain line.
  // Note: the rail indicator is a logic level, not the analogue supply.
  // Note: during sleep the clear-to-send line stays high so the host
  // cannot mistake a sleeping module for one that is ready.

endmodule : mpss_device

// ==== logic/mpss_host.sv ====
// Host end: drives power request, emergency reset and commands
`timescale 1ns/1ps
module mpss_host
  import mpss_pkg::*;
#(
  parameter logic [31:0] PWR_ON_CYC = PWR_ON_MIN_CYC,
  parameter logic [31:0] EMERG_CYC = EMERG_PULSE_CYC,
  parameter logic [31:0] HANG_CYC = HANG_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  mpss_link_if.host link,
  input wire logic start,
  input wire logic power_off,
  input wire logic set_policy,
  input wire logic [1:0] policy_arg,
  input wire logic emergency,
  input wire logic wake,
  input wire logic use_usb,
  input wire logic dtr_n_in,
  output logic link_ready,
  output logic frozen,
  output logic busy
);

  typedef struct packed {
    mpss_host_state_e state;
    logic [31:0] cnt;
    logic pwr_drive;
    logic rst_n;
    logic cts_prev;
    logic cmd_valid;
    logic [1:0] cmd_op;
    logic [1:0] cmd_arg;
    logic ser_valid;
    logic dtr_n;
    logic frozen;
  } mpss_host_s;

  mpss_host_s state_ff;
  mpss_host_s nxt_state;

  // Pin outputs from flip-flops except usb_enum_done, made from use_usb and the rail, and the constant pwr_out and ser_data; enable is low while sinking the line
  always_comb begin
    link.pwr_out = 1'b0;
    link.pwr_oe_n = ~state_ff.pwr_drive;
    link.emerg_reset_n = state_ff.rst_n;
    link.dtr_n = state_ff.dtr_n;
    link.ser_valid = state_ff.ser_valid;
    link.ser_data = WAKE_CHAR;
    link.cmd_valid = state_ff.cmd_valid;
    link.cmd_op = state_ff.cmd_op;
    link.cmd_arg = state_ff.cmd_arg;
    link.usb_enum_done = use_usb && link.io_supply_indicator;
    link_ready = (state_ff.state == HOST_READY);
    frozen = state_ff.frozen;
    busy = (state_ff.state != HOST_READY) && (state_ff.state != HOST_OFF);
  end

  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_state.ser_valid = 1'b0;
    nxt_state.dtr_n = dtr_n_in;
    nxt_state.cts_prev = link.host_uart_clear_to_send;
    case (state_ff.state)
      HOST_OFF: begin
        if (start) begin
          nxt_state.state = HOST_START;
          nxt_state.pwr_drive = 1'b1;
          nxt_state.cnt = CNT_RST;
        end
      end
      // Hold the request low for the full minimum, then let it float
      HOST_START: begin
        nxt_state.cnt = state_ff.cnt + 32'h1;
        if (state_ff.cnt == PWR_ON_CYC - 32'h1) begin
          nxt_state.pwr_drive = 1'b0;
          nxt_state.state = HOST_WAIT;
        end
      end
      // Ready on a clear-to-send fall, or on USB after enumeration
      HOST_WAIT: begin
        if ((state_ff.cts_prev && !link.host_uart_clear_to_send) || (use_usb && link.usb_ready)) begin
          nxt_state.state = HOST_READY;
        end
      end
      HOST_READY: begin
        nxt_state.cnt = CNT_RST;
        if (emergency || power_off) begin
          // Without a freeze, emergency requests become orderly power-off
          nxt_state.state = HOST_CMD;
          nxt_state.cmd_valid = 1'b1;
          nxt_state.cmd_op = CMD_POWER_OFF;
        end else if (set_policy) begin
          nxt_state.state = HOST_CMD;
          nxt_state.cmd_valid = 1'b1;
          nxt_state.cmd_op = CMD_SLEEP_POLICY;
          nxt_state.cmd_arg = use_usb ? POLICY_AUTO : policy_arg;
        end else if (wake) begin
          nxt_state.ser_valid = 1'b1;
        end
      end
      // Wait for the module; a long silence marks it frozen
      HOST_CMD: begin
        nxt_state.cnt = state_ff.cnt + 32'h1;
        if (link.cmd_ready) begin
          nxt_state.cmd_valid = 1'b0;
          nxt_state.state = (state_ff.cmd_op == CMD_POWER_OFF) ? HOST_OFF : HOST_READY;
        end else if (wake) begin
          nxt_state.ser_valid = 1'b1;
        end else if (state_ff.cnt == HANG_CYC - 32'h1) begin
          nxt_state.frozen = 1'b1;
        end
        if (state_ff.frozen && emergency) begin
          nxt_state.cmd_valid = 1'b0;
          nxt_state.state = HOST_RESET;
          nxt_state.rst_n = 1'b0;
          nxt_state.pwr_drive = 1'b0;
          nxt_state.cnt = CNT_RST;
        end
      end
      // Emergency pulse with the power request released
      HOST_RESET: begin
        nxt_state.cnt = state_ff.cnt + 32'h1;
        if (state_ff.cnt == EMERG_CYC - 32'h1) begin
          nxt_state.rst_n = 1'b1;
          nxt_state.frozen = 1'b0;
          nxt_state.state = HOST_OFF;
        end
      end
      default: begin
        nxt_state.state = HOST_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff.state <= HOST_OFF;
      state_ff.cnt <= CNT_RST;
      state_ff.pwr_drive <= 1'b0;
      state_ff.rst_n <= 1'b1;
      state_ff.cts_prev <= 1'b1;
      state_ff.cmd_valid <= 1'b0;
      state_ff.cmd_op <= CMD_NONE;
      state_ff.cmd_arg <= POLICY_RST;
      state_ff.ser_valid <= 1'b0;
      state_ff.dtr_n <= 1'b1;
      state_ff.frozen <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : mpss_host

// ==== logic/mpss_link_if.sv ====
// Control pins and command channel between host and module
`timescale 1ns/1ps
interface mpss_link_if;
  logic pwr_out;
  logic pwr_oe_n;
  logic power_on_request_n;
  logic emerg_reset_n;
  logic io_supply_indicator;
  logic host_uart_clear_to_send;
  logic dtr_n;
  logic ser_valid;
  logic [7:0] ser_data;
  logic usb_enum_done;
  logic usb_ready;
  logic cmd_valid;
  logic [1:0] cmd_op;
  logic [1:0] cmd_arg;
  logic cmd_ready;

  // Internal pull-up: the line reads high unless the host sinks it
  assign power_on_request_n = pwr_oe_n ? 1'b1 : pwr_out;

  modport dev (
    input power_on_request_n,
    input emerg_reset_n,
    output io_supply_indicator,
    output host_uart_clear_to_send,
    input dtr_n,
    input ser_valid,
    input ser_data,
    input usb_enum_done,
    output usb_ready,
    input cmd_valid,
    input cmd_op,
    input cmd_arg,
    output cmd_ready
  );

  modport host (
    output pwr_out,
    output pwr_oe_n,
    input power_on_request_n,
    output emerg_reset_n,
    input io_supply_indicator,
    input host_uart_clear_to_send,
    output dtr_n,
    output ser_valid,
    output ser_data,
    output usb_enum_done,
    input usb_ready,
    output cmd_valid,
    output cmd_op,
    output cmd_arg,
    input cmd_ready
  );
endinterface : mpss_link_if

// ==== logic/mpss_pkg.sv ====
// Shared constants and types for the power and sleep sequencer ends
package mpss_pkg;
  // Clock rate in hertz and kilohertz
  localparam longint CLK_HZ = 250_000_000;
  localparam longint CLK_KHZ = CLK_HZ / 1000;
  // Times in their own units
  localparam longint PWR_ON_MIN_MS = 25;
  localparam longint RAIL_RISE_MS = 25;
  localparam longint CMD_READY_S = 7;
  localparam longint EMERG_PULSE_MS = 20;
  localparam longint SLEEP_DELAY_MS = 1;
  localparam longint HANG_TIMEOUT_MS = 100;
  // Cycle counts derived from the times (least times, exact multiples)
  localparam logic [31:0] PWR_ON_MIN_CYC = 32'(PWR_ON_MIN_MS * CLK_KHZ);
  localparam logic [31:0] RAIL_RISE_CYC = 32'(RAIL_RISE_MS * CLK_KHZ);
  localparam logic [31:0] CMD_READY_CYC = 32'(CMD_READY_S * CLK_HZ);
  localparam logic [31:0] EMERG_PULSE_CYC = 32'(EMERG_PULSE_MS * CLK_KHZ);
  localparam logic [31:0] SLEEP_DELAY_CYC = 32'(SLEEP_DELAY_MS * CLK_KHZ);
  localparam logic [31:0] HANG_TIMEOUT_CYC = 32'(HANG_TIMEOUT_MS * CLK_KHZ);
  // Reset values
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [1:0] SYNC_RST = 2'h3;
  // Commands on the command channel
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_SLEEP_POLICY = 2'h1;
  localparam logic [1:0] CMD_POWER_OFF = 2'h2;
  // Sleep policies
  localparam logic [1:0] POLICY_DTR = 2'h0;
  localparam logic [1:0] POLICY_AUTO = 2'h1;
  localparam logic [1:0] POLICY_NEVER = 2'h2;
  localparam logic [1:0] POLICY_RST = POLICY_DTR;
  // Serial wake character
  localparam logic [7:0] WAKE_CHAR = 8'h00;
  // Device states
  typedef enum logic [1:0] {
    DEV_OFF = 2'b00,
    DEV_BOOT = 2'b01,
    DEV_READY = 2'b10,
    DEV_SLEEP = 2'b11
  } mpss_dev_state_e;
  // Host states
  typedef enum logic [2:0] {
    HOST_OFF = 3'b000,
    HOST_START = 3'b001,
    HOST_WAIT = 3'b010,
    HOST_READY = 3'b011,
    HOST_CMD = 3'b100,
    HOST_RESET = 3'b101
  } mpss_host_state_e;
endpackage : mpss_pkg

// ==== test/mpss_props.sv ====
// Timing checks on the link between the host and module ends
`timescale 1ns/1ps
module mpss_props
  import mpss_pkg::*;
#(
  parameter int PWR_CYC = 10,
  parameter int EMG_CYC = 8,
  parameter int RDY_CYC = 40
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pwr_oe_n,
  input wire logic power_on_request_n,
  input wire logic emerg_reset_n,
  input wire logic io_supply_indicator,
  input wire logic host_uart_clear_to_send,
  input wire logic usb_enum_done,
  input wire logic usb_ready,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_ready
);
  // Margins cover the two-flop input synchroniser lag
  localparam int PWR_MAX = PWR_CYC + 4;
  localparam int RDY_GAP = RDY_CYC - PWR_CYC + 4;
  logic [31:0] pwr_run_ff;
  logic [31:0] emg_run_ff;
  logic pwr_low_ff;
  logic emg_low_ff;
  logic off_taken;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  assign off_taken = cmd_valid && cmd_ready && (cmd_op == CMD_POWER_OFF);

  // Length of the latest low run on each host line, held after release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwr_low_ff <= 1'b0;
      emg_low_ff <= 1'b0;
      pwr_run_ff <= 32'h0;
      emg_run_ff <= 32'h0;
    end else begin
      pwr_low_ff <= !power_on_request_n;
      emg_low_ff <= !emerg_reset_n;
      if (!power_on_request_n) pwr_run_ff <= pwr_low_ff ? pwr_run_ff + 32'h1 : 32'h1;
      if (!emerg_reset_n) emg_run_ff <= emg_low_ff ? emg_run_ff + 32'h1 : 32'h1;
    end
  end

  host_pwr_len_a: assert property ($rose(pwr_oe_n) |-> pwr_run_ff == 32'(PWR_CYC))
    else $error("power request low time wrong");
  rail_after_low_a: assert property ($rose(io_supply_indicator) |-> pwr_run_ff >= 32'(PWR_CYC))
    else $error("rail rose before full request time");
  rail_rise_time_a: assert property ($fell(power_on_request_n) && !io_supply_indicator
    |-> ##[PWR_CYC:PWR_MAX] $rose(io_supply_indicator)) else $error("rail did not rise in time");
  boot_cts_hold_a: assert property ($rose(io_supply_indicator) |-> host_uart_clear_to_send [*8])
    else $error("clear to send fell too early");
  cts_ready_time_a: assert property ($rose(io_supply_indicator)
    |-> ##[1:RDY_GAP] $fell(host_uart_clear_to_send)) else $error("commands not ready in time");
  cmd_gate_a: assert property (cmd_ready |-> !host_uart_clear_to_send && io_supply_indicator)
    else $error("command taken while not ready");
  usb_gate_a: assert property (usb_ready |-> usb_enum_done && io_supply_indicator)
    else $error("usb ready before enumeration");
  off_cmd_a: assert property (off_taken |=> !io_supply_indicator && host_uart_clear_to_send)
    else $error("power off command not obeyed");
  host_emerg_len_a: assert property ($rose(emerg_reset_n)
    |-> emg_run_ff == 32'(EMG_CYC) && power_on_request_n) else $error("emergency pulse malformed");
  emerg_fire_a: assert property ($rose(emerg_reset_n) && emg_run_ff >= 32'(EMG_CYC) && io_supply_indicator
    |-> ##[0:4] !io_supply_indicator) else $error("emergency pulse did not shut down");
  rail_drop_cause_a: assert property ($fell(io_supply_indicator)
    |-> $past(off_taken) || emg_run_ff >= 32'(EMG_CYC)) else $error("rail dropped without cause");
endmodule : mpss_props

// ==== test/mpss_tb.sv ====
// Self-checking bench joining the host end and the module end
`timescale 1ns/1ps
module mpss_tb
  import mpss_pkg::*;
;
  // Short counts keep the run brief; host and module must agree
  localparam logic [31:0] T_PWR = 32'h0000000a;
  localparam logic [31:0] T_RDY = 32'h00000028;
  localparam logic [31:0] T_EMG = 32'h00000008;
  localparam logic [31:0] T_SLP = 32'h00000005;
  localparam logic [31:0] T_HANG = 32'h00000014;
  logic clk;
  logic reset;
  logic tasks_idle;
  logic powered;
  logic sleeping;
  logic mem_clear;
  logic [1:0] policy;
  logic start;
  logic power_off;
  logic set_policy;
  logic [1:0] policy_arg;
  logic emergency;
  logic wake;
  logic use_usb;
  logic dtr_n_in;
  logic link_ready;
  logic frozen;
  logic busy;
  int err_total;
  int compares;
  int clr_count;

  mpss_link_if i_mpss_link_if();

  mpss_device #(.PWR_ON_CYC(T_PWR), .READY_CYC(T_RDY), .EMERG_CYC(T_EMG), .SLEEP_CYC(T_SLP)) i_mpss_device (
    .clk(clk), .reset(reset), .link(i_mpss_link_if), .tasks_idle(tasks_idle),
    .powered(powered), .sleeping(sleeping), .mem_clear(mem_clear), .policy(policy));

  mpss_host #(.PWR_ON_CYC(T_PWR), .EMERG_CYC(T_EMG), .HANG_CYC(T_HANG)) i_mpss_host (
    .clk(clk), .reset(reset), .link(i_mpss_link_if), .start(start), .power_off(power_off),
    .set_policy(set_policy), .policy_arg(policy_arg), .emergency(emergency), .wake(wake),
    .use_usb(use_usb), .dtr_n_in(dtr_n_in), .link_ready(link_ready), .frozen(frozen), .busy(busy));

  mpss_props #(.PWR_CYC(int'(T_PWR)), .EMG_CYC(int'(T_EMG)), .RDY_CYC(int'(T_RDY))) i_mpss_props (
    .clk(clk), .reset(reset), .pwr_oe_n(i_mpss_link_if.pwr_oe_n),
    .power_on_request_n(i_mpss_link_if.power_on_request_n), .emerg_reset_n(i_mpss_link_if.emerg_reset_n),
    .io_supply_indicator(i_mpss_link_if.io_supply_indicator),
    .host_uart_clear_to_send(i_mpss_link_if.host_uart_clear_to_send),
    .usb_enum_done(i_mpss_link_if.usb_enum_done), .usb_ready(i_mpss_link_if.usb_ready),
    .cmd_valid(i_mpss_link_if.cmd_valid), .cmd_op(i_mpss_link_if.cmd_op), .cmd_ready(i_mpss_link_if.cmd_ready));

  // Clock
  always #2 clk = ~clk;

  // Memory clear pulses, counted to catch a repeat firing
  always @(posedge clk) if (mem_clear === 1'b1) clr_count++;

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Bounded wait for the host to report a usable link
  task wait_ready();
    int n;
    n = 0;
    while (link_ready !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(link_ready, 1'b1, "link ready");
  endtask : wait_ready

  task cmd(input logic [1:0] arg);
    policy_arg = arg;
    set_policy = 1'b1;
    cyc(1);
    set_policy = 1'b0;
    cyc(2);
    wait_ready();
  endtask : cmd

  // Start-up, timing the rail and clear-to-send from the start request
  task boot();
    int n;
    n = 0;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    while (powered !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= T_PWR && n <= T_PWR + 6), 32'h1, "rail rise time");
    while (i_mpss_link_if.host_uart_clear_to_send !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= T_RDY - 4 && n <= T_RDY + 6), 32'h1, "command ready time");
    wait_ready();
  endtask : boot

  task conclude();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // Watchdog sized well above the expected few hundred cycles
  initial begin
    #20000;
    err_total++;
    conclude();
  end

  initial begin
    {clk, tasks_idle, start, power_off, set_policy, emergency, wake, use_usb} = 8'h0;
    policy_arg = 2'h0;
    dtr_n_in = 1'b0;
    {err_total, compares, clr_count} = {32'h0, 32'h0, 32'h0};
    reset = 1'b1;
    cyc(4);
    reset = 1'b0;
    chk(powered, 1'b0, "rail after reset");
    chk(i_mpss_link_if.host_uart_clear_to_send, 1'b1, "cts after reset");
    chk(policy, POLICY_RST, "policy after reset");
    boot();
    // Never-sleep policy ignores both idle tasks and a high DTR
    cmd(POLICY_NEVER);
    chk(policy, POLICY_NEVER, "policy never");
    tasks_idle = 1'b1;
    dtr_n_in = 1'b1;
    cyc(4 * T_SLP);
    chk(sleeping, 1'b0, "never sleeps");
    dtr_n_in = 1'b0;
    tasks_idle = 1'b0;
    cmd(POLICY_DTR);
    dtr_n_in = 1'b1;
    cyc(T_SLP + 6);
    chk(sleeping, 1'b1, "dtr sleep");
    chk(i_mpss_link_if.host_uart_clear_to_send, 1'b1, "cts in sleep");
    dtr_n_in = 1'b0;
    cyc(4);
    chk(sleeping, 1'b0, "dtr wake");
    wait_ready();
    cmd(2'h3);
    chk(policy, POLICY_DTR, "reserved policy ignored");
    cmd(POLICY_AUTO);
    tasks_idle = 1'b1;
    cyc(3);
    chk(sleeping, 1'b1, "idle sleep");
    tasks_idle = 1'b0;
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    cyc(3);
    chk(sleeping, 1'b0, "wake char");
    wait_ready();
    use_usb = 1'b1;
    cyc(2);
    chk(i_mpss_link_if.usb_ready, 1'b1, "usb ready");
    cmd(POLICY_DTR);
    chk(policy, POLICY_AUTO, "usb forces auto");
    // Orderly off keeps the policy
    power_off = 1'b1;
    cyc(1);
    power_off = 1'b0;
    cyc(4);
    chk(powered, 1'b0, "off rail");
    chk(i_mpss_link_if.host_uart_clear_to_send, 1'b1, "off cts");
    chk(i_mpss_link_if.usb_ready, 1'b0, "off usb");
    chk(policy, POLICY_AUTO, "off keeps policy");
    use_usb = 1'b0;
    boot();
    // Asleep module refuses the command, host declares it frozen
    tasks_idle = 1'b1;
    cyc(3);
    chk(sleeping, 1'b1, "asleep");
    policy_arg = POLICY_NEVER;
    set_policy = 1'b1;
    cyc(1);
    set_policy = 1'b0;
    cyc(2 * T_HANG + 8);
    chk(frozen, 1'b1, "host frozen");
    chk(busy, 1'b1, "host busy on hang");
    emergency = 1'b1;
    cyc(1);
    emergency = 1'b0;
    cyc(T_EMG + 10);
    chk(powered, 1'b0, "emergency rail");
    chk(policy, POLICY_RST, "emergency policy");
    chk(clr_count, 32'h1, "memory clear once");
    chk(frozen, 1'b0, "freeze cleared");
    chk(busy, 1'b0, "host idle after pulse");
    tasks_idle = 1'b0;
    boot();
    conclude();
  end
endmodule : mpss_tb
